/* logic/pto_top.sv */
// Turn-on timeout response, turn-off timing settings and summary status registers.
`timescale 1ns/1ps
`include "pto_regs.svh"
module pto_top #(
  parameter int unsigned MS_CYCLES = `PTO_MS_CYCLES,
  parameter int unsigned HICCUP_CYCLES = `PTO_HICCUP_CYCLES,
  parameter int unsigned N_OTHER = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  // Command port from the bus transaction engine.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ack,
  output logic cmd_miss,
  output logic [15:0] cmd_rdata,
  // Fault sources and clearing.
  input wire logic ton_max_fault,
  input wire logic clear_faults,
  input wire logic ton_max_alert_mask,
  input wire logic pec_fault,
  input wire logic invalid_command,
  // On/off control.
  input wire logic enable_pin,
  input wire logic operation_off,
  input wire logic other_fault_shutdown,
  input wire logic stop_active,
  // Monitor levels for the summary status.
  input wire logic nvm_busy,
  input wire logic output_off,
  input wire logic vout_ovp_fault,
  input wire logic iout_oc_peak_fault,
  input wire logic temp_fault_warn,
  input wire logic vout_status_other,
  input wire logic iout_status_any,
  input wire logic input_status_any,
  input wire logic mfr_status_any,
  input wire logic [N_OTHER-1:0] other_faults,
  input wire logic power_good,
  // Open-drain alert pin.
  input wire logic host_alert_n_in,
  output logic host_alert_n_out,
  output logic host_alert_n_oe,
  // Power stage controls and settings.
  output logic output_disable,
  output logic restart_pulse,
  output logic energy_stop,
  output logic vout_zero_cmd,
  output logic vout_ton_max_flag,
  output logic [39:0] nvm_image
);
  import pto_pkg::*;

  function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] target);
    is_cmd = (code == target);
  endfunction : is_cmd

  // Unsupported action, retry or delay field makes the byte unacceptable.
  function automatic logic resp_ok(input logic [7:0] d);
    logic act_ok;
    logic retry_ok;
    act_ok = (d[7:6] == `PTO_ACT_IGNORE) || (d[7:6] == `PTO_ACT_SHUTDOWN);
    retry_ok = (d[5:3] == `PTO_RETRY_LATCH) || (d[5:3] == `PTO_RETRY_HICCUP);
    resp_ok = act_ok && retry_ok && (d[2:0] == 3'h0);
  endfunction : resp_ok

  function automatic logic delay_ok(input logic [15:0] d);
    delay_ok = (d[15:11] == 5'h00) && (d[10:4] == 7'h00);
  endfunction : delay_ok

  function automatic logic fall_ok(input logic [15:0] d);
    fall_ok = (d[15:11] == 5'h00) && (d[10:5] == 6'h00) && (d[4:0] != 5'h00);
  endfunction : fall_ok

  pto_ctl_if ctl ();

  pto_restart #(
    .HICCUP_CYCLES(HICCUP_CYCLES)
  ) u_restart (
    .clock(clock),
    .rst_n(rst_n),
    .ctl(ctl)
  );

  // Setting registers.
  pto_resp_t resp;
  logic [15:0] turnoff_wait_time;
  logic [15:0] turnoff_ramp_time;

  // Sticky flags.
  logic ton_max_sticky;
  logic invalid_data_sticky;
  logic comm_fault_summary;

  // Enable pin synchroniser; the first stage feeds only the second.
  logic enable_meta;
  logic enable_sync;

  logic wr_hit;
  logic rd_hit;
  logic wr_resp;
  logic wr_delay;
  logic wr_fall;
  logic wr_bad;
  logic [7:0] status_low;
  logic [7:0] status_high;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable_meta <= 1'b0;
      enable_sync <= 1'b0;
    end else begin
      enable_meta <= enable_pin;
      enable_sync <= enable_meta;
    end
  end

  // Command decode.
  assign wr_resp = cmd_valid && cmd_write && is_cmd(cmd_code, `PTO_CMD_TONMAX_RESP);
  assign wr_delay = cmd_valid && cmd_write && is_cmd(cmd_code, `PTO_CMD_TURNOFF_WAIT_TIME);
  assign wr_fall = cmd_valid && cmd_write && is_cmd(cmd_code, `PTO_CMD_TURNOFF_RAMP_TIME);
  assign wr_hit = wr_resp || wr_delay || wr_fall;
  assign rd_hit = is_cmd(cmd_code, `PTO_CMD_TONMAX_RESP)
               || is_cmd(cmd_code, `PTO_CMD_TURNOFF_WAIT_TIME)
               || is_cmd(cmd_code, `PTO_CMD_TURNOFF_RAMP_TIME)
               || is_cmd(cmd_code, `PTO_CMD_STATUS_BYTE)
               || is_cmd(cmd_code, `PTO_CMD_STATUS_WORD);
  assign wr_bad = (wr_resp && !resp_ok(cmd_wdata[7:0]))
               || (wr_delay && !delay_ok(cmd_wdata))
               || (wr_fall && !fall_ok(cmd_wdata));

  // Response byte; a rejected write leaves it as it was.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resp <= `PTO_RST_TONMAX_RESP;
    end else if (wr_resp && resp_ok(cmd_wdata[7:0])) begin
      resp <= cmd_wdata[7:0];
    end
  end

  // Turn-off delay; the exponent can only be written as zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      turnoff_wait_time <= `PTO_RST_TURNOFF_WAIT_TIME;
    end else if (wr_delay && delay_ok(cmd_wdata)) begin
      turnoff_wait_time <= cmd_wdata;
    end
  end

  // Turn-off fall time.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      turnoff_ramp_time <= `PTO_RST_TURNOFF_RAMP_TIME;
    end else if (wr_fall && fall_ok(cmd_wdata)) begin
      turnoff_ramp_time <= cmd_wdata;
    end
  end

  // The store engine samples this image when the save-all command runs.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nvm_image <= {`PTO_RST_TONMAX_RESP, `PTO_RST_TURNOFF_WAIT_TIME, `PTO_RST_TURNOFF_RAMP_TIME};
    end else begin
      nvm_image <= {resp, turnoff_wait_time, turnoff_ramp_time};
    end
  end

  // Timeout flag: a new event in the clearing cycle keeps it set.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ton_max_sticky <= 1'b0;
    end else if (ton_max_fault) begin
      ton_max_sticky <= 1'b1;
    end else if (clear_faults) begin
      ton_max_sticky <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      invalid_data_sticky <= 1'b0;
    end else if (wr_bad) begin
      invalid_data_sticky <= 1'b1;
    end else if (clear_faults) begin
      invalid_data_sticky <= 1'b0;
    end
  end

  // Communication summary also catches checksum and unknown-command faults.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      comm_fault_summary <= 1'b0;
    end else if (wr_bad || pec_fault || invalid_command) begin
      comm_fault_summary <= 1'b1;
    end else if (clear_faults) begin
      comm_fault_summary <= 1'b0;
    end
  end

  assign vout_ton_max_flag = ton_max_sticky;

  // Summary status assembled from monitor levels, the sequencer output disable and the timeout and communication sticky flags.
  always_comb begin
    status_low = 8'h00;
    status_low[7] = nvm_busy;
    status_low[6] = output_off || ctl.out_disable;
    status_low[5] = vout_ovp_fault;
    status_low[4] = iout_oc_peak_fault;
    status_low[2] = temp_fault_warn;
    status_low[1] = comm_fault_summary;
    status_low[0] = |other_faults;
  end

  always_comb begin
    status_high = 8'h00;
    status_high[7] = vout_status_other || ton_max_sticky;
    status_high[6] = iout_status_any;
    status_high[5] = input_status_any;
    status_high[4] = mfr_status_any;
    status_high[3] = !power_good;
  end

  // Read data and acknowledge, one cycle after the request.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_ack <= 1'b0;
      cmd_miss <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      cmd_ack <= cmd_valid && (rd_hit || wr_hit);
      cmd_miss <= cmd_valid && !rd_hit;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          `PTO_CMD_TONMAX_RESP: cmd_rdata <= {8'h00, resp};
          `PTO_CMD_TURNOFF_WAIT_TIME: cmd_rdata <= turnoff_wait_time;
          `PTO_CMD_TURNOFF_RAMP_TIME: cmd_rdata <= turnoff_ramp_time;
          `PTO_CMD_STATUS_BYTE: cmd_rdata <= {8'h00, status_low};
          `PTO_CMD_STATUS_WORD: cmd_rdata <= {status_high, status_low};
          default: cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Alert pin is pulled low while an unmasked fault is held.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_alert_n_oe <= 1'b0;
    end else begin
      host_alert_n_oe <= (ton_max_sticky && !ton_max_alert_mask)
                      || invalid_data_sticky
                      || comm_fault_summary;
    end
  end

  assign host_alert_n_out = 1'b0;

  // Hand the fault and the response setting to the restart sequencer.
  assign ctl.fault_evt = ton_max_fault;
  assign ctl.resp = resp;
  assign ctl.cmd_off = !enable_sync || operation_off;
  assign ctl.other_shutdown = other_fault_shutdown;
  assign ctl.clear = clear_faults;
  assign output_disable = ctl.out_disable;
  assign restart_pulse = ctl.restart;

  // Turn-off sequence: wait the delay, stop switching, then ramp to zero.
  pto_off_state_t off_state;
  logic [31:0] tick_cnt;
  logic tick;
  logic [4:0] ms_left;

  // Millisecond tick, restarted at each sequence step so steps are whole.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
    end else if (off_state == PTO_OFF_IDLE || tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  assign tick = (tick_cnt == MS_CYCLES - 1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      off_state <= PTO_OFF_IDLE;
      ms_left <= 5'h00;
      energy_stop <= 1'b0;
      vout_zero_cmd <= 1'b0;
    end else if (!stop_active) begin
      off_state <= PTO_OFF_IDLE;
      energy_stop <= 1'b0;
      vout_zero_cmd <= 1'b0;
    end else begin
      case (off_state)
        PTO_OFF_IDLE: begin
          // The delay is captured here; the fall time is read only when the ramp step starts.
          if (turnoff_wait_time[4:0] == 5'h00) begin
            energy_stop <= 1'b1;
            ms_left <= turnoff_ramp_time[4:0];
            off_state <= PTO_OFF_RAMP;
          end else begin
            ms_left <= turnoff_wait_time[4:0];
            off_state <= PTO_OFF_WAIT;
          end
        end
        PTO_OFF_WAIT: begin
          if (tick) begin
            if (ms_left == 5'h01) begin
              energy_stop <= 1'b1;
              ms_left <= turnoff_ramp_time[4:0];
              off_state <= PTO_OFF_RAMP;
            end else begin
              ms_left <= ms_left - 5'h01;
            end
          end
        end
        PTO_OFF_RAMP: begin
          if (tick) begin
            if (ms_left == 5'h01) begin
              vout_zero_cmd <= 1'b1;
              off_state <= PTO_OFF_DONE;
            end else begin
              ms_left <= ms_left - 5'h01;
            end
          end
        end
        PTO_OFF_DONE: begin
          off_state <= PTO_OFF_DONE;
        end
        default: begin
          off_state <= PTO_OFF_IDLE;
        end
      endcase
    end
  end
endmodule : pto_top

/* logic/pto_regs.svh */
// Command codes, field positions, reset values and timing counts of the turn-off and status block.
//
// Summary of operation
// - Turn-on timeout sets summary, status bit, alert
// - Timeout bit sticky until clear-faults
// - Response byte resets to latch-off 0x80
// - Action 00 ignore, 10 shutdown, others unsupported
// - Retry 000 stays off until cleared
// - Retry 111 hiccups every second until stopped
// - Unsupported response encodings raise invalid data
// - Turn-off delay, 0-10 ms, resets 0; the code accepts 0-15 ms
// - Delay: nonzero exponent or bits 10:4 invalid
// - Turn-off fall, 1-20 ms, resets 5; the code accepts 1-31 ms
// - Fall: exponent, bits 10:5, zero invalid
// - Three settings offered to nonvolatile store
// - Status byte bit 7 shows memory busy
// - Status byte bits 6,5,4,2,1 report faults
// - Status byte bit 0 ORs other faults
// - Status word low byte is status byte
// - Status word high bits 7,6,5,4 summarise
// - Status word bit 11 is inverted power good
// - Timeout flag is bit 2, alert-maskable
`ifndef PTO_REGS_SVH
`define PTO_REGS_SVH
`define PTO_CMD_TONMAX_RESP 8'h63
`define PTO_CMD_TURNOFF_WAIT_TIME 8'h64
`define PTO_CMD_TURNOFF_RAMP_TIME 8'h65
`define PTO_CMD_STATUS_BYTE 8'h78
`define PTO_CMD_STATUS_WORD 8'h79
`define PTO_RST_TONMAX_RESP 8'h80
`define PTO_RST_TURNOFF_WAIT_TIME 16'h0000
`define PTO_RST_TURNOFF_RAMP_TIME 16'h0005
`define PTO_ACT_IGNORE 2'h0
`define PTO_ACT_SHUTDOWN 2'h2
`define PTO_RETRY_LATCH 3'h0
`define PTO_RETRY_HICCUP 3'h7
`define PTO_VOUT_TONMAX_BIT 2
`define PTO_CLK_PERIOD_NS 10
`define PTO_MS_NS 1000000
`define PTO_HICCUP_S 1
`define PTO_MS_CYCLES (`PTO_MS_NS / `PTO_CLK_PERIOD_NS)
`define PTO_HICCUP_CYCLES (`PTO_HICCUP_S * 1000000000 / `PTO_CLK_PERIOD_NS)
`endif

/* logic/pto_pkg.sv */
// Types shared by the turn-off and status block.
package pto_pkg;
  typedef struct packed {
    logic [1:0] action;
    logic [2:0] retry;
    logic [2:0] delay;
  } pto_resp_t;
  typedef enum logic [1:0] {PTO_RUN, PTO_LATCHED, PTO_HICCUP} pto_rst_state_t;
  typedef enum logic [1:0] {PTO_OFF_IDLE, PTO_OFF_WAIT, PTO_OFF_RAMP, PTO_OFF_DONE} pto_off_state_t;
endpackage : pto_pkg

/* logic/pto_ctl_if.sv */
// Control link between the register core and the fault restart sequencer.
`timescale 1ns/1ps
interface pto_ctl_if;
  import pto_pkg::*;
  logic fault_evt;
  pto_resp_t resp;
  logic cmd_off;
  logic other_shutdown;
  logic clear;
  logic out_disable;
  logic restart;
  modport core (output fault_evt, resp, cmd_off, other_shutdown, clear,
                input out_disable, restart);
  modport seq (input fault_evt, resp, cmd_off, other_shutdown, clear,
               output out_disable, restart);
endinterface : pto_ctl_if

/* logic/pto_restart.sv */
// Turn-on timeout fault response: ignore, latch off or hiccup restart.
`timescale 1ns/1ps
`include "pto_regs.svh"
module pto_restart #(
  parameter int unsigned HICCUP_CYCLES = `PTO_HICCUP_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  pto_ctl_if.seq ctl
);
  import pto_pkg::*;

  pto_rst_state_t state;
  logic [31:0] wait_cnt;
  logic restart;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= PTO_RUN;
      wait_cnt <= 32'h0;
      restart <= 1'b0;
    end else begin
      restart <= 1'b0;
      case (state)
        PTO_RUN: begin
          // Action 00 keeps running; 01 and 11 can never be stored.
          if (ctl.fault_evt && ctl.resp.action == `PTO_ACT_SHUTDOWN) begin
            wait_cnt <= 32'h0;
            if (ctl.resp.retry == `PTO_RETRY_HICCUP) begin
              state <= PTO_HICCUP;
            end else begin
              state <= PTO_LATCHED;
            end
          end
        end
        PTO_LATCHED: begin
          if (ctl.clear) begin
            state <= PTO_RUN;
          end
        end
        PTO_HICCUP: begin
          // A command off ends the retries; the next enable starts normally.
          if (ctl.other_shutdown) begin
            state <= PTO_LATCHED;
          end else if (ctl.cmd_off || ctl.clear) begin
            state <= PTO_RUN;
          end else if (wait_cnt == HICCUP_CYCLES - 1) begin
            state <= PTO_RUN;
            restart <= 1'b1;
          end else begin
            wait_cnt <= wait_cnt + 32'h1;
          end
        end
        default: begin
          state <= PTO_RUN;
        end
      endcase
    end
  end

  assign ctl.out_disable = (state != PTO_RUN);
  assign ctl.restart = restart;
endmodule : pto_restart

/* tb/pto_chk.sv */
// Port-level assertions for the turn-off and status block.
`timescale 1ns/1ps
module pto_chk (
  input logic clock,
  input logic rst_n,
  input logic cmd_valid,
  input logic cmd_write,
  input logic [7:0] cmd_code,
  input logic [15:0] cmd_rdata,
  input logic ton_max_fault,
  input logic clear_faults,
  input logic ton_max_alert_mask,
  input logic power_good,
  input logic stop_active,
  input logic host_alert_n_oe,
  input logic output_disable,
  input logic restart_pulse,
  input logic energy_stop,
  input logic vout_zero_cmd,
  input logic vout_ton_max_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rd79 = cmd_valid && !cmd_write && cmd_code == 8'h79;
  property p_set; ton_max_fault |=> vout_ton_max_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; vout_ton_max_flag && !clear_faults |=> vout_ton_max_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_alert;
    ton_max_fault && !ton_max_alert_mask ##1 !ton_max_alert_mask |=> host_alert_n_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("no alert");
  property p_pg; rd79 && $stable(power_good) |=> cmd_rdata[11] == !$past(power_good); endproperty
  a_pg: assert property (p_pg) else $error("power good bit");
  property p_vsum; rd79 && vout_ton_max_flag && $past(vout_ton_max_flag) |=> cmd_rdata[15]; endproperty
  a_vsum: assert property (p_vsum) else $error("vout summary");
  property p_offclr; $fell(stop_active) |=> !energy_stop && !vout_zero_cmd; endproperty
  a_offclr: assert property (p_offclr) else $error("turn-off not reset");
  property p_zero; vout_zero_cmd |-> energy_stop; endproperty
  a_zero: assert property (p_zero) else $error("zero before stop");
  property p_restart; restart_pulse |-> !output_disable ##1 !restart_pulse; endproperty
  a_restart: assert property (p_restart) else $error("restart pulse");
  c_fault: cover property (ton_max_fault ##1 vout_ton_max_flag);
  c_restart: cover property (restart_pulse);
  c_zero: cover property ($rose(vout_zero_cmd));
endmodule : pto_chk
bind pto_top pto_chk u_pto_chk (.*);

/* tb/pto_host.sv */
// Command host model that issues one read or write at a time.
`timescale 1ns/1ps
module pto_host (
  input logic clock,
  input logic cmd_ack,
  input logic cmd_miss,
  input logic [15:0] cmd_rdata,
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [15:0] cmd_wdata = 16'h0000
);
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic [1:0] r);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    // Stale data would hide a core that samples the bus late, so it is inverted.
    cmd_wdata = ~d;
    r = 2'b00;
    n = 0;
    while (r == 2'b00 && n < 4) begin
      r = {cmd_miss, cmd_ack};
      q = cmd_rdata;
      if (r == 2'b00) @(negedge clock);
      n++;
    end
  endtask : xfer
endmodule : pto_host

/* tb/pto_top_bench.sv */
// Self-checking bench: register access, status walks, fault and turn-off sequences.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module pto_top_bench;
  localparam int MS = 4;
  localparam int HIC = 10;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_ack, cmd_miss, ton_max_fault, clear_faults, pec_fault;
  logic ton_max_alert_mask, invalid_command, enable_pin, operation_off, power_good;
  logic other_fault_shutdown, stop_active, host_alert_n_out, host_alert_n_oe;
  logic output_disable, restart_pulse, energy_stop, vout_zero_cmd, vout_ton_max_flag;
  logic [7:0] cmd_code, other_faults;
  logic [15:0] cmd_wdata, cmd_rdata;
  logic [39:0] nvm_image;
  logic [8:0] mon;
  wire host_alert_n_in = !host_alert_n_oe;
  wire [2:0] evt = {restart_pulse, vout_zero_cmd, energy_stop};
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] st_exp [9] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0004, 16'h8000,
    16'h4000, 16'h2000, 16'h1000};
  logic [23:0] good_w [5] = '{24'h630000, 24'h6300b8, 24'h64000a, 24'h650001, 24'h650014};
  logic [23:0] bad_w [10] = '{24'h630040, 24'h6300c0, 24'h630088, 24'h6300b0, 24'h6300b9,
    24'h640800, 24'h640010, 24'h650000, 24'h650020, 24'h650801};
  logic [8:0] to_w [4] = '{9'h080, 9'h180, 9'h000, 9'h0b8};
  pto_top #(.MS_CYCLES(MS), .HICCUP_CYCLES(HIC)) u_pto_top (.*, .nvm_busy(mon[0]),
    .output_off(mon[1]), .vout_ovp_fault(mon[2]), .iout_oc_peak_fault(mon[3]),
    .temp_fault_warn(mon[4]), .vout_status_other(mon[5]), .iout_status_any(mon[6]),
    .input_status_any(mon[7]), .mfr_status_any(mon[8]));
  pto_host u_pto_host (.*);
  always #5 clock = ~clock;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic [15:0] q);
    logic [1:0] r;
    u_pto_host.xfer(w, c, d, q, r);
    `CHK("answer", (c inside {8'h63, 8'h64, 8'h65, 8'h78, 8'h79}) ? 2'b01 : 2'b10, r)
    // A host that never saw an answer has already counted the mismatch above.
    if (r == 2'b00) begin
      test_done();
    end
  endtask : acc
  task automatic rdchk(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    acc(1'b0, c, 16'h0000, q);
    `CHK($sformatf("cmd %h", c), e & m, q & m & ((c == 8'h63) ? 16'h00ff : 16'hffff))
  endtask : rdchk
  task automatic fault();
    ton_max_fault = 1'b1;
    cyc(1);
    ton_max_fault = 1'b0;
    cyc(2);
  endtask : fault
  task automatic clr();
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(2);
  endtask : clr
  task automatic wait_evt(input int s, output int n);
    n = 0;
    while (evt[s] !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    if (n == 60) begin
      err_total++;
      test_done();
    end
  endtask : wait_evt
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    logic [15:0] q;
    int n;
    {ton_max_fault, clear_faults, ton_max_alert_mask, pec_fault, invalid_command} = 5'h00;
    {enable_pin, operation_off, other_fault_shutdown, stop_active, power_good} = 5'h11;
    mon = 9'h000;
    other_faults = 8'h00;
    cyc(20);
    rst_n = 1'b1;
    rdchk(8'h63, 16'hffff, 16'h0080);
    rdchk(8'h64, 16'hffff, 16'h0000);
    rdchk(8'h65, 16'hffff, 16'h0005);
    `CHK("image", 40'h8000000005, nvm_image)
    acc(1'b0, 8'h7a, 16'h0000, q);
    acc(1'b1, 8'h79, 16'hffff, q);
    rdchk(8'h79, 16'hffff, 16'h0000);
    $display("test reset done");
    foreach (good_w[i]) begin
      acc(1'b1, good_w[i][23:16], good_w[i][15:0], q);
      rdchk(good_w[i][23:16], 16'hffff, good_w[i][15:0]);
    end
    rdchk(8'h78, 16'h0002, 16'h0000);
    `CHK("image", {8'hb8, 16'h000a, 16'h0014}, nvm_image)
    foreach (bad_w[i]) begin
      acc(1'b1, bad_w[i][23:16], bad_w[i][15:0], q);
      rdchk(bad_w[i][23:16], 16'hffff, (bad_w[i][17:16] == 2'h3) ? 16'h00b8 :
        (bad_w[i][16] ? 16'h0014 : 16'h000a));
      rdchk(8'h78, 16'h0002, 16'h0002);
      clr();
      rdchk(8'h78, 16'h0002, 16'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      {pec_fault, invalid_command} = k ? 2'b10 : 2'b01;
      cyc(1);
      {pec_fault, invalid_command} = 2'b00;
      rdchk(8'h78, 16'h0002, 16'h0002);
      clr();
    end
    $display("test settings done");
    for (int i = 0; i < 9; i++) begin
      mon = 9'h001 << i;
      cyc(2);
      rdchk(8'h79, (i < 5) ? 16'h00ff : 16'hff00, st_exp[i]);
      if (i < 5) rdchk(8'h78, 16'h00ff, st_exp[i]);
    end
    mon = 9'h000;
    for (int k = 0; k < 8; k++) begin
      other_faults = 8'h01 << k;
      cyc(2);
      rdchk(8'h78, 16'h00ff, 16'h0001);
    end
    other_faults = 8'h00;
    power_good = 1'b0;
    cyc(2);
    rdchk(8'h79, 16'hff00, 16'h0800);
    power_good = 1'b1;
    $display("test status done");
    foreach (to_w[i]) begin
      acc(1'b1, 8'h63, {8'h00, to_w[i][7:0]}, q);
      ton_max_alert_mask = to_w[i][8];
      fault();
      `CHK("flag", 1'b1, vout_ton_max_flag)
      `CHK("alert", !to_w[i][8], host_alert_n_oe)
      `CHK("alert pin", 1'b0, host_alert_n_out)
      `CHK("disable", to_w[i][7], output_disable)
      if (to_w[i][3]) begin
        wait_evt(2, n);
        `CHK("hiccup", 1'b1, n >= HIC - 3 && n <= HIC + 1)
      end else begin
        cyc(3 * HIC);
        `CHK("latched", to_w[i][7], output_disable)
      end
      rdchk(8'h79, 16'h8000, 16'h8000);
      clr();
      `CHK("cleared", 3'h0, {vout_ton_max_flag, host_alert_n_oe, output_disable})
    end
    ton_max_alert_mask = 1'b0;
    for (int k = 0; k < 3; k++) begin
      fault();
      {other_fault_shutdown, enable_pin, operation_off} = (k == 0) ? 3'b011 :
        (k == 1) ? 3'b000 : 3'b110;
      cyc(5);
      `CHK("stop", k == 2, output_disable)
      cyc(3 * HIC);
      `CHK("stop held", k == 2, output_disable)
      {other_fault_shutdown, enable_pin, operation_off} = 3'b010;
      clr();
    end
    $display("test timeout done");
    acc(1'b1, 8'h65, 16'h0003, q);
    for (int d = 0; d < 3; d += 2) begin
      acc(1'b1, 8'h64, 16'(d), q);
      stop_active = 1'b1;
      wait_evt(0, n);
      `CHK("delay", 1'b1, n >= d * MS && n <= d * MS + 3)
      wait_evt(1, n);
      `CHK("fall", 1'b1, n >= 3 * MS - 1 && n <= 3 * MS + 3)
      stop_active = 1'b0;
      cyc(2);
    end
    $display("test turnoff done");
    test_done();
  end
  initial begin
    cyc(30000);
    err_total++;
    test_done();
  end
endmodule : pto_top_bench
